/* rtl/cmpr_reset_ctrl.v */
`timescale 1ns/1ps
`include "cmpr_defines.vh"

// Functional notes
// - Compare live config with complement shadows only in run state
// - Mismatch clears flag; block reset sets it; other resets keep it
// - Mismatch is hard reset; reload config words
// - Power-up timer can never be disabled
// - Hold reset while RC-clocked timer counts
// - Timer starts after power-on pulse ends
// - Pin released after timer expiry: run immediately
module cmpr_reset_ctrl #(
    parameter WORDS     = `CMPR_CFG_WORDS,
    parameter WIDTH     = `CMPR_CFG_WIDTH,
    parameter PUT_COUNT = `CMPR_PUT_COUNT
) (
    // Clock and reset
    input  wire                   CLK,
    input  wire                   NRST,
    // Reset sources
    input  wire                   POR_ACTIVE,
    input  wire                   MASTER_CLEAR_PIN_N,
    input  wire                   RESET_INSTR,
    input  wire                   WATCHDOG_TIMEOUT,
    input  wire                   STACK_EVENT,
    input  wire                   CLOCK_READY,
    // RC oscillator tick
    input  wire                   INTERNAL_RC_TICK,
    // Flash copy of the configuration words
    input  wire [WORDS*WIDTH-1:0] FLASH_CFG,
    // Live configuration corruption injection
    input  wire [WORDS*WIDTH-1:0] CFG_UPSET,
    // Outputs
    output reg                    CORE_RESET_N,
    output reg                    CONFIG_MISMATCH_FLAG,
    output reg  [WORDS*WIDTH-1:0] CFG_WORDS
);
    localparam [1:0] ST_POR   = `CMPR_ST_POR;
    localparam [1:0] ST_LOAD  = `CMPR_ST_LOAD;
    localparam [1:0] ST_TIMER = `CMPR_ST_TIMER;
    localparam [1:0] ST_RUN   = `CMPR_ST_RUN;
    localparam       TOTAL    = WORDS * WIDTH;

    reg  [1:0]       state_q;
    reg  [1:0]       state_d;
    reg  [TOTAL-1:0] shadow_q;
    reg  [TOTAL-1:0] shadow_d;
    reg  [TOTAL-1:0] cfg_d;
    reg  [WORDS-1:0] word_bad;
    reg              mismatch_q;
    reg              mismatch_d;
    reg              flag_d;
    reg              core_run_d;
    reg              ext_reset;
    reg              hard_reset;
    reg              release_ok;
    integer          w;
    wire             put_expired;

    // A pair disagrees when any live bit equals its shadow bit; the
    // complement form means a single upset on either side shows up
    function word_mismatch;
        input [WIDTH-1:0] live;
        input [WIDTH-1:0] shadow;
        begin
            word_mismatch = |(live & shadow) | ~&(live | shadow);
        end
    endfunction

    // Only power-on or block reset restarts the count, so other hard
    // resets recover in two cycles once the timer has already expired
    cmpr_put_timer #(
        .COUNT (PUT_COUNT),
        .WIDTH (`CMPR_PUT_WIDTH)
    ) u_put (
        .clk        (CLK),
        .nrst       (NRST),
        .por_active (POR_ACTIVE),
        .rc_tick    (INTERNAL_RC_TICK),
        .expired_q  (put_expired)
    );

    // Sources that restart through a reload of the configuration words
    always @* begin
        ext_reset  = !MASTER_CLEAR_PIN_N || RESET_INSTR || WATCHDOG_TIMEOUT || STACK_EVENT;
        hard_reset = ext_reset || mismatch_q;
    end

    // Leaving the timer state needs expiry, a released pin and a clock
    always @* begin
        release_ok = put_expired && MASTER_CLEAR_PIN_N && CLOCK_READY;
    end

    // Each word pair is compared on its own, every cycle
    always @* begin
        word_bad = {WORDS{1'b0}};
        for (w = 0; w < WORDS; w = w + 1) begin
            word_bad[w] = word_mismatch(CFG_WORDS[w*WIDTH +: WIDTH],
                                        shadow_q[w*WIDTH +: WIDTH]);
        end
    end

    always @* begin
        mismatch_d = 1'b0;
        // Checked only in run; during reload both copies are in flux
        if (state_q == ST_RUN) begin
            mismatch_d = |word_bad;
        end
    end

    // Reload sequencer: power-on, reload, timer hold, run
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_POR: begin
                // Wait for the power-on pulse to clear
                if (!POR_ACTIVE) begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                // One cycle to take the flash copy
                state_d = ST_TIMER;
            end
            ST_TIMER: begin
                // Pin held low past expiry: release starts code at once
                if (release_ok) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (hard_reset) begin
                    state_d = ST_LOAD;
                end
            end
            default: begin
                state_d = ST_POR;
            end
        endcase
        // The power-on pulse overrides every other source
        if (POR_ACTIVE) begin
            state_d = ST_POR;
        end
    end

    // A reload rewrites both copies, so stale upsets cannot survive it
    always @* begin
        cfg_d    = CFG_WORDS ^ CFG_UPSET;
        shadow_d = shadow_q;
        if (state_d == ST_LOAD) begin
            cfg_d    = FLASH_CFG;
            shadow_d = ~FLASH_CFG;
        end
    end

    // The flag is only ever cleared here; only the block reset sets it
    always @* begin
        flag_d = CONFIG_MISMATCH_FLAG;
        if (mismatch_q) begin
            flag_d = 1'b0;
        end
    end

    // Held in reset while the timer still counts
    always @* begin
        core_run_d = (state_d == ST_RUN);
    end

    always @(posedge CLK) begin
        if (!NRST) begin
            state_q <= ST_POR;
        end else begin
            state_q <= state_d;
        end
    end

    // Registered so the core reset output is free of glitches
    always @(posedge CLK) begin
        if (!NRST) begin
            CORE_RESET_N <= 1'b0;
        end else begin
            CORE_RESET_N <= core_run_d;
        end
    end

    // Live words take injected upsets on every clock edge except the one that enters reload
    always @(posedge CLK) begin
        if (!NRST) begin
            CFG_WORDS <= {TOTAL{1'b0}};
        end else begin
            CFG_WORDS <= cfg_d;
        end
    end

    // Reset values are each other's complement, so no false mismatch
    always @(posedge CLK) begin
        if (!NRST) begin
            shadow_q <= {TOTAL{1'b1}};
        end else begin
            shadow_q <= shadow_d;
        end
    end

    // Registered so a glitch in the wide compare cannot reset the core
    always @(posedge CLK) begin
        if (!NRST) begin
            mismatch_q <= 1'b0;
        end else begin
            mismatch_q <= mismatch_d;
        end
    end

    // Power-on value: no mismatch seen since the block reset
    always @(posedge CLK) begin
        if (!NRST) begin
            CONFIG_MISMATCH_FLAG <= `CMPR_CM_FLAG_POR;
        end else begin
            CONFIG_MISMATCH_FLAG <= flag_d;
        end
    end
endmodule

/* rtl/cmpr_defines.vh */
`ifndef CMPR_DEFINES_VH
`define CMPR_DEFINES_VH

// Configuration store geometry
`define CMPR_CFG_WORDS      4
`define CMPR_CFG_WIDTH      16
// Power-up timer terminal count, in cycles of the RC oscillator tick
`define CMPR_PUT_COUNT      64
`define CMPR_PUT_WIDTH      16
// Reset value of the mismatch flag after a block reset
`define CMPR_CM_FLAG_POR    1'b1
// Reload sequencer states
`define CMPR_ST_POR         2'h0
`define CMPR_ST_LOAD        2'h1
`define CMPR_ST_TIMER       2'h2
`define CMPR_ST_RUN         2'h3

`endif

/* rtl/cmpr_put_timer.v */
`timescale 1ns/1ps
`include "cmpr_defines.vh"

// Power-up timer: counts RC oscillator ticks once the power-on pulse is gone.
module cmpr_put_timer #(
    parameter COUNT = `CMPR_PUT_COUNT,
    parameter WIDTH = `CMPR_PUT_WIDTH
) (
    // Clock and reset
    input  wire clk,
    input  wire nrst,
    // Control
    input  wire por_active,
    input  wire rc_tick,
    // Status
    output reg  expired_q
);
    // Terminal count cut to the counter width on purpose
    localparam [31:0]      LAST_FULL = COUNT - 1;
    localparam [WIDTH-1:0] LAST      = LAST_FULL[WIDTH-1:0];

    reg [WIDTH-1:0] cnt_q;

    // No enable input exists, so nothing can switch the timer off
    always @(posedge clk) begin
        if (!nrst || por_active) begin
            cnt_q     <= {WIDTH{1'b0}};
            expired_q <= 1'b0;
        end else if (!expired_q && rc_tick) begin
            if (cnt_q == LAST) begin
                expired_q <= 1'b1;
            end
            cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

/* testbench/cmpr_partner.sv */
`timescale 1ns/1ps
// Power-on detector and master clear pin
module cmpr_partner (
    // Clock
    input  wire  clk,
    // Pins
    output logic por_active,
    output logic master_clear_pin_n
);
    initial begin
        por_active = 1'b1;
        master_clear_pin_n     = 1'b1;
    end
    // Pulse ends on a falling edge, away from the sampling edge
    task automatic power_on(input int n);
        @(negedge clk);
        por_active = 1'b1;
        repeat (n) @(negedge clk);
        por_active = 1'b0;
    endtask
endmodule

/* testbench/cmpr_reset_ctrl_sva.sv */
`timescale 1ns/1ps
module cmpr_reset_ctrl_chk #(parameter WORDS = 4, WIDTH = 16, PUT_COUNT = 64) (
    // Inputs
    input wire                   CLK,
    input wire                   NRST,
    input wire                   POR_ACTIVE,
    input wire                   MASTER_CLEAR_PIN_N,
    input wire                   RESET_INSTR,
    input wire                   CLOCK_READY,
    input wire [WORDS*WIDTH-1:0] FLASH_CFG,
    input wire [WORDS*WIDTH-1:0] CFG_UPSET,
    // Outputs
    input wire                   CORE_RESET_N,
    input wire                   CONFIG_MISMATCH_FLAG,
    input wire [WORDS*WIDTH-1:0] CFG_WORDS
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    sequence held_s;
        !CORE_RESET_N [*5];
    endsequence
    por_hold_a: assert property (POR_ACTIVE |=> !CORE_RESET_N)
        else $error("core ran in power-on");
    timer_hold_a: assert property ($fell(POR_ACTIVE) |-> held_s)
        else $error("timer hold too short");
    cfg_reload_a: assert property ($fell(POR_ACTIVE) |-> ##[1:2] CFG_WORDS == FLASH_CFG)
        else $error("config not reloaded");
    upset_detect_a: assert property (CORE_RESET_N && CFG_UPSET != 0 |-> ##[3:4] !CONFIG_MISMATCH_FLAG)
        else $error("mismatch missed");
    flag_up_a: assert property ($rose(CONFIG_MISMATCH_FLAG) |-> !$past(NRST))
        else $error("flag set outside reset");
    flag_down_a: assert property ($fell(CONFIG_MISMATCH_FLAG) |-> $past(CORE_RESET_N))
        else $error("flag cleared while held");
    hard_reset_a: assert property (CORE_RESET_N && (RESET_INSTR || !MASTER_CLEAR_PIN_N) |=> !CORE_RESET_N)
        else $error("hard reset ignored");
    pin_release_a: assert property ($rose(CORE_RESET_N) |-> $past(MASTER_CLEAR_PIN_N)
        && $past(CLOCK_READY) && !$past(POR_ACTIVE))
        else $error("run with pin low");
endmodule
bind cmpr_reset_ctrl cmpr_reset_ctrl_chk #(.WORDS(WORDS), .WIDTH(WIDTH), .PUT_COUNT(PUT_COUNT))
    i_chk (.*);

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        tick = 1'b0;
    logic        crdy = 1'b1;
    logic [2:0]  src = 3'h0;
    logic [63:0] upset = 64'h0;
    logic        por, master_clear_pin_n, core_n, flag;
    logic [63:0] cfg;
    int          err_total = 0;
    int          n_checks = 0;
    // Row: {stack, watchdog, instr, expected flag}
    logic [3:0]  rows [3] = '{4'h3, 4'h5, 4'h9};
    localparam logic [63:0] FL = 64'h1234_5678_9abc_def0;
    always #50 clk = ~clk;
    always @(negedge clk) tick <= ~tick;
    cmpr_partner i_cmpr_partner (.clk(clk), .por_active(por), .master_clear_pin_n(master_clear_pin_n));
    cmpr_reset_ctrl #(.PUT_COUNT(4)) i_cmpr_reset_ctrl (.CLK(clk), .NRST(nrst),
        .POR_ACTIVE(por), .MASTER_CLEAR_PIN_N(master_clear_pin_n), .RESET_INSTR(src[0]),
        .WATCHDOG_TIMEOUT(src[1]), .STACK_EVENT(src[2]), .CLOCK_READY(crdy),
        .INTERNAL_RC_TICK(tick), .FLASH_CFG(FL), .CFG_UPSET(upset),
        .CORE_RESET_N(core_n), .CONFIG_MISMATCH_FLAG(flag), .CFG_WORDS(cfg));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wait_run;
        repeat (40) begin
            @(negedge clk);
            if (core_n === 1'b1) break;
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #300000;
        err_total++;
        test_done;
    end
    initial begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        i_cmpr_partner.power_on(3);
        chk(core_n, 1'b0);
        @(negedge clk);
        chk(cfg, FL);
        wait_run;
        chk(core_n, 1'b1);
        $display("power-up done");
        foreach (rows[i]) begin
            src = rows[i][3:1];
            @(negedge clk);
            src = 3'h0;
            chk(core_n, 1'b0);
            wait_run;
            chk(flag, rows[i][0]);
            $display("row %0d done", i);
        end
        upset = 64'h1;
        @(negedge clk);
        upset = 64'h0;
        repeat (3) @(negedge clk);
        chk(flag, 1'b0);
        chk(core_n, 1'b0);
        chk(cfg, FL);
        wait_run;
        chk(core_n, 1'b1);
        $display("mismatch done");
        i_cmpr_partner.master_clear_pin_n = 1'b0;
        i_cmpr_partner.power_on(2);
        repeat (20) @(negedge clk);
        chk(core_n, 1'b0);
        i_cmpr_partner.master_clear_pin_n = 1'b1;
        @(negedge clk);
        chk(core_n, 1'b1);
        $display("pin release done");
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        chk(flag, 1'b1);
        chk(core_n, 1'b0);
        crdy = 1'b0;
        i_cmpr_partner.power_on(2);
        repeat (20) @(negedge clk);
        chk(core_n, 1'b0);
        crdy = 1'b1;
        @(negedge clk);
        chk(core_n, 1'b1);
        chk(flag, 1'b1);
        $display("block reset done");
        test_done;
    end
endmodule
